/* src/sfr_register_map.sv */
`timescale 1ns/1ps
module sfr_register_map (
  input wire logic core_clk_i,
  input wire logic reset_i,
  // service request, same clock domain as the core
  input wire logic req_valid_i,
  input wire logic req_set_i,
  input wire logic [sfr_pkg::INST_W-1:0] req_instance_i,
  input wire logic [sfr_pkg::DATA_W-1:0] req_data_i,
  // service answer
  output logic resp_valid_o,
  output logic resp_error_o,
  output logic [sfr_pkg::DATA_W-1:0] resp_data_o,
  output logic [sfr_pkg::DATA_W-1:0] resp_data_hi_o,
  // measurements from same-clock conversion logic
  input wire logic [sfr_pkg::DATA_W-1:0] read_measured_current_i,
  input wire logic [sfr_pkg::DATA_W-1:0] read_measured_voltage_i,
  input wire logic [sfr_pkg::DATA_W-1:0] read_measured_power_i,
  // live conditions from the power stage pins
  input wire logic volt_protect_fault_i,
  input wire logic curr_trip_fault_i,
  input wire logic volt_trip_fault_i,
  input wire logic power_trip_fault_i,
  input wire logic curr_protect_fault_i,
  input wire logic temp_protect_fault_i,
  input wire logic sense_lost_fault_i,
  input wire logic regulating_current_i,
  input wire logic regulating_voltage_i,
  input wire logic regulating_resistance_i,
  input wire logic regulating_power_i,
  input wire logic interlock_open_flag_i,
  input wire logic input_supply_lost_i,
  input wire logic io_input_fault_i,
  input wire logic [31:0] op_status_i,
  input wire logic [31:0] op_status_word1_i,
  // control outputs toward the power stage
  output logic output_enable_o,
  output logic config_locked_o,
  output logic restore_defaults_o,
  output logic target_update_o,
  output logic [sfr_pkg::SET_IDX_W-1:0] target_index_o,
  output logic [sfr_pkg::DATA_W-1:0] target_data_o
);

  // carrier toward the settings store
  sfr_cfg_if cfg ();

  // live status words
  logic [31:0] ques_w;
  logic [31:0] word0_w;
  logic [31:0] word1_w;

  // device control state
  logic output_on_r;
  logic lock_r;

  // stage between request and answer
  logic pend_r;
  logic pend_err_r;
  logic pend_from_mem_r;
  logic [sfr_pkg::DATA_W-1:0] pend_data_r;
  logic [sfr_pkg::DATA_W-1:0] pend_hi_r;

  // registered answer and control outputs
  logic resp_valid_r;
  logic resp_error_r;
  logic [sfr_pkg::DATA_W-1:0] resp_data_r;
  logic [sfr_pkg::DATA_W-1:0] resp_hi_r;
  logic restore_r;
  logic upd_r;
  logic [sfr_pkg::SET_IDX_W-1:0] upd_idx_r;
  logic [sfr_pkg::DATA_W-1:0] upd_data_r;

  // condition pins gathered in questionable order
  // order matters: index n here is questionable bit n for bits 0..10
  wire logic [sfr_pkg::COND_W-1:0] cond_raw = {
    io_input_fault_i, input_supply_lost_i, interlock_open_flag_i,
    regulating_power_i, regulating_resistance_i, regulating_voltage_i,
    regulating_current_i, sense_lost_fault_i, temp_protect_fault_i,
    curr_protect_fault_i, power_trip_fault_i, volt_trip_fault_i,
    curr_trip_fault_i, volt_protect_fault_i
  };

  sfr_status_assembler u_status (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .cond_i(cond_raw),
    .op_status_i(op_status_i),
    .op_status_word1_i(op_status_word1_i),
    .output_on_i(output_on_r),
    .ques_o(ques_w),
    .word0_o(word0_w),
    .word1_o(word1_w)
  );

  // settings held in their own store with a registered read
  sfr_settings_store u_store (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .cfg(cfg)
  );

  // request qualifiers
  wire logic is_get = req_valid_i & ~req_set_i;
  wire logic is_set = req_valid_i & req_set_i;

  // per-setting instance match, write side and read-back side
  logic [sfr_pkg::NUM_SET-1:0] set_hit;
  logic [sfr_pkg::NUM_SET-1:0] get_hit;
  genvar gi;
  generate
    for (gi = 0; gi < sfr_pkg::NUM_SET; gi++) begin : g_match
      assign set_hit[gi] = (req_instance_i == sfr_pkg::SET_WR_INST[gi]);
      assign get_hit[gi] = (req_instance_i ==
                            sfr_pkg::SET_WR_INST[gi] + sfr_pkg::INST_READBACK_STEP);
    end
  endgenerate

  // encode the matching entry; at most one can match
  logic [sfr_pkg::SET_IDX_W-1:0] set_idx;
  logic [sfr_pkg::SET_IDX_W-1:0] get_idx;
  always_comb begin
    set_idx = '0;
    get_idx = '0;
    for (int i = 0; i < sfr_pkg::NUM_SET; i++) begin
      if (set_hit[i]) begin
        set_idx = i[sfr_pkg::SET_IDX_W-1:0];
      end
      if (get_hit[i]) begin
        get_idx = i[sfr_pkg::SET_IDX_W-1:0];
      end
    end
  end

  // fixed instance decode
  wire logic hit_ques = (req_instance_i == sfr_pkg::INST_QUES_RD);
  wire logic hit_status = (req_instance_i == sfr_pkg::INST_STATUS_RD);
  wire logic hit_out_wr = (req_instance_i == sfr_pkg::INST_OUTPUT_WR);
  wire logic hit_out_rd = (req_instance_i == sfr_pkg::INST_OUTPUT_RD);
  wire logic hit_meas_i = (req_instance_i == sfr_pkg::INST_MEAS_CURR_RD);
  wire logic hit_meas_v = (req_instance_i == sfr_pkg::INST_MEAS_VOLT_RD);
  wire logic hit_meas_p = (req_instance_i == sfr_pkg::INST_MEAS_PWR_RD);
  wire logic hit_restore = (req_instance_i == sfr_pkg::INST_RESTORE_WR);
  wire logic hit_lock_rd = (req_instance_i == sfr_pkg::INST_LOCK_RD);
  wire logic hit_lock_wr = (req_instance_i == sfr_pkg::INST_LOCK_WR);

  // lock blocks settings writes and the factory restore
  wire logic set_write = is_set & (|set_hit) & ~lock_r;
  wire logic restore_go = is_set & hit_restore & ~lock_r;
  wire logic out_write = is_set & hit_out_wr;
  wire logic lock_write = is_set & hit_lock_wr;

  wire logic get_ok = |get_hit | hit_ques | hit_status | hit_out_rd
                    | hit_meas_i | hit_meas_v | hit_meas_p | hit_lock_rd;
  wire logic set_ok = set_write | restore_go | out_write | lock_write;

  // anything else is an error and changes nothing
  // a refused request still answers, so the originator never waits on it
  wire logic req_err = req_valid_i & (req_set_i ? ~set_ok : ~(is_get & get_ok));

  // direct answer word for instances not served by the store
  logic [sfr_pkg::DATA_W-1:0] direct_data;
  always_comb begin
    direct_data = 32'h0000_0000;
    if (hit_ques) begin
      direct_data = ques_w;
    // word 0 first, word 1 on the high lane
    end else if (hit_status) begin
      direct_data = word0_w;
    end else if (hit_out_rd) begin
      direct_data = {31'h0000_0000, output_on_r};
    end else if (hit_meas_i) begin
      direct_data = read_measured_current_i;
    end else if (hit_meas_v) begin
      direct_data = read_measured_voltage_i;
    end else if (hit_meas_p) begin
      direct_data = read_measured_power_i;
    end else if (hit_lock_rd) begin
      direct_data = {31'h0000_0000, lock_r};
    end
  end

  // store port driven straight from the decode
  assign cfg.wr_en = set_write;
  assign cfg.wr_idx = set_idx;
  assign cfg.wr_data = req_data_i;
  assign cfg.restore = restore_go;
  assign cfg.rd_idx = get_idx;

  // output control; a hard fault forces standby over a write
  // a cleared fault does not turn the output back on; a new write is needed
  wire logic hard_fault = ques_w[sfr_pkg::Q_ANY_HARD];
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      output_on_r <= sfr_pkg::OUTPUT_RESET;
    end else if (hard_fault) begin
      output_on_r <= 1'b0;
    end else if (out_write) begin
      output_on_r <= req_data_i[0];
    end
  end

  // lock bit itself is always writable
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_r <= sfr_pkg::LOCK_RESET;
    end else if (lock_write) begin
      lock_r <= req_data_i[0];
    end
  end

  // first stage: wait for the store's registered read
  // direct words are captured here so both sources line up in the answer
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_r <= 1'b0;
      pend_err_r <= 1'b0;
      pend_from_mem_r <= 1'b0;
      pend_data_r <= '0;
      pend_hi_r <= '0;
    end else begin
      pend_r <= req_valid_i;
      pend_err_r <= req_err;
      pend_from_mem_r <= is_get & (|get_hit);
      pend_data_r <= (is_get & ~req_err) ? direct_data : '0;
      pend_hi_r <= (is_get & hit_status) ? word1_w : '0;
    end
  end

  // second stage: the answer, one cycle wide
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      resp_valid_r <= 1'b0;
      resp_error_r <= 1'b0;
      resp_data_r <= '0;
      resp_hi_r <= '0;
    end else begin
      resp_valid_r <= pend_r;
      resp_error_r <= pend_r & pend_err_r;
      resp_data_r <= pend_from_mem_r ? cfg.rd_data : pend_data_r;
      resp_hi_r <= pend_hi_r;
    end
  end

  // notify the power stage of accepted changes, one cycle pulses
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      restore_r <= 1'b0;
      upd_r <= 1'b0;
      upd_idx_r <= '0;
      upd_data_r <= '0;
    end else begin
      restore_r <= restore_go;
      upd_r <= set_write;
      upd_idx_r <= set_write ? set_idx : upd_idx_r;
      upd_data_r <= set_write ? req_data_i : upd_data_r;
    end
  end

  assign resp_valid_o = resp_valid_r;
  assign resp_error_o = resp_error_r;
  assign resp_data_o = resp_data_r;
  assign resp_data_hi_o = resp_hi_r;
  assign output_enable_o = output_on_r;
  assign config_locked_o = lock_r;
  assign restore_defaults_o = restore_r;
  assign target_update_o = upd_r;
  assign target_index_o = upd_idx_r;
  assign target_data_o = upd_data_r;

endmodule

/* src/sfr_pkg.sv */
package sfr_pkg;

  // widths of the service port
  localparam int INST_W = 16;
  localparam int DATA_W = 32;

  // instances that are not settings
  localparam logic [15:0] INST_QUES_RD = 16'h000B;
  localparam logic [15:0] INST_STATUS_RD = 16'h000D;
  localparam logic [15:0] INST_OUTPUT_WR = 16'h000F;
  localparam logic [15:0] INST_OUTPUT_RD = 16'h0010;
  localparam logic [15:0] INST_MEAS_CURR_RD = 16'h0101;
  localparam logic [15:0] INST_MEAS_VOLT_RD = 16'h0102;
  localparam logic [15:0] INST_MEAS_PWR_RD = 16'h0103;
  localparam logic [15:0] INST_RESTORE_WR = 16'h0701;
  localparam logic [15:0] INST_LOCK_RD = 16'h0702;
  localparam logic [15:0] INST_LOCK_WR = 16'h0703;

  // settings store: write instances, read instance is always write plus one
  localparam int NUM_SET = 16;
  localparam int SET_IDX_W = 4;
  localparam logic [15:0] INST_READBACK_STEP = 16'h0001;
  localparam logic [15:0] SET_WR_INST [NUM_SET] = '{
    16'h0201, 16'h0203, 16'h0205,             // current, voltage, power targets
    16'h0301, 16'h0303, 16'h0305, 16'h0307,   // high current/voltage/power, low voltage
    16'h0401, 16'h0403, 16'h0405,             // rising slews
    16'h0409, 16'h040B, 16'h040D,             // falling slews
    16'h0503,                                 // regulation_control_select
    16'h0706,                                 // sense_point_config
    16'h070A                                  // target_origin_select
  };
  localparam logic [31:0] SET_RESET_VAL = 32'h0000_0000;

  // reset values of the device's own control state
  localparam logic OUTPUT_RESET = 1'b0;
  localparam logic LOCK_RESET = 1'b0;

  // raw condition vector, in questionable order for bits 0..10
  localparam int COND_W = 14;
  localparam int C_VOLT_PROT = 0;
  localparam int C_CURR_TRIP = 1;
  localparam int C_VOLT_TRIP = 2;
  localparam int C_PWR_TRIP = 3;
  localparam int C_CURR_PROT = 4;
  localparam int C_TEMP_PROT = 5;
  localparam int C_SENSE_LOST = 6;
  localparam int C_REG_CURR = 7;
  localparam int C_REG_POWER = 10;
  localparam int C_INTERLOCK = 11;
  localparam int C_SUPPLY_LOST = 12;
  localparam int C_IO_FAULT = 13;

  // questionable register field positions
  localparam int Q_VOLT_PROT = 0;
  localparam int Q_CURR_TRIP = 1;
  localparam int Q_VOLT_TRIP = 2;
  localparam int Q_PWR_TRIP = 3;
  localparam int Q_CURR_PROT = 4;
  localparam int Q_TEMP_PROT = 5;
  localparam int Q_SENSE_LOST = 6;
  localparam int Q_REG_CURR = 7;
  localparam int Q_REG_POWER = 10;
  localparam int Q_ANY_SOFT = 11;
  localparam int Q_ANY_HARD = 12;
  localparam int Q_INTERLOCK = 13;
  localparam int Q_SUPPLY_LOST = 14;
  localparam int Q_IO_FAULT = 15;

  // status word 0 field positions owned by the device itself
  localparam int W0_STANDBY = 0;
  localparam int W0_LIVE = 1;
  localparam int W0_CURR_TRIP = 4;
  localparam int W0_VOLT_TRIP = 5;
  localparam int W0_PWR_TRIP = 6;
  localparam int W0_INTERLOCK = 20;
  // bits 2, 3, 21 and 31 are unused and read as zero
  localparam logic [31:0] W0_USED_MASK = 32'h7FDF_FFF3;

endpackage

/* src/sfr_cfg_if.sv */
`timescale 1ns/1ps
// path between the service decoder and the settings store
interface sfr_cfg_if;
  logic wr_en;
  logic [sfr_pkg::SET_IDX_W-1:0] wr_idx;
  logic [sfr_pkg::DATA_W-1:0] wr_data;
  logic restore;
  logic [sfr_pkg::SET_IDX_W-1:0] rd_idx;
  logic [sfr_pkg::DATA_W-1:0] rd_data;

  modport ctrl (output wr_en, output wr_idx, output wr_data, output restore,
                output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input restore,
                 input rd_idx, output rd_data);
endinterface

/* src/sfr_settings_store.sv */
`timescale 1ns/1ps
module sfr_settings_store (
  input wire logic core_clk_i,
  input wire logic reset_i,
  sfr_cfg_if.store cfg
);

  // one word per setting, all held in flops
  logic [sfr_pkg::DATA_W-1:0] entry_r [sfr_pkg::NUM_SET];
  // registered read word
  logic [sfr_pkg::DATA_W-1:0] rd_data_r;

  genvar gi;
  generate
    for (gi = 0; gi < sfr_pkg::NUM_SET; gi++) begin : g_entry
      // per-entry write enable from the index decode
      wire logic hit = cfg.wr_en && (cfg.wr_idx == sfr_pkg::SET_IDX_W'(gi));
      // restore outranks a write landing in the same cycle
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          entry_r[gi] <= sfr_pkg::SET_RESET_VAL;
        end else if (cfg.restore) begin
          entry_r[gi] <= sfr_pkg::SET_RESET_VAL;
        end else if (hit) begin
          entry_r[gi] <= cfg.wr_data;
        end
      end
    end
  endgenerate

  // read port: old data on a same-cycle write, data appears one edge later
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_r <= sfr_pkg::SET_RESET_VAL;
    end else begin
      rd_data_r <= entry_r[cfg.rd_idx];
    end
  end

  assign cfg.rd_data = rd_data_r;

endmodule

/* src/sfr_status_assembler.sv */
`timescale 1ns/1ps
module sfr_status_assembler (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [sfr_pkg::COND_W-1:0] cond_i,
  input wire logic [31:0] op_status_i,
  input wire logic [31:0] op_status_word1_i,
  input wire logic output_on_i,
  output logic [31:0] ques_o,
  output logic [31:0] word0_o,
  output logic [31:0] word1_o
);

  localparam int SYNC_W = sfr_pkg::COND_W + 64;

  // two-stage synchroniser; stage one is read only by stage two
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [31:0] ques_r;
  logic [31:0] word0_r;
  logic [31:0] word1_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {op_status_word1_i, op_status_i, cond_i};
      sync2_r <= sync1_r;
    end
  end

  // settled copies of the pins
  wire logic [sfr_pkg::COND_W-1:0] cond = sync2_r[sfr_pkg::COND_W-1:0];
  wire logic [31:0] op = sync2_r[sfr_pkg::COND_W +: 32];
  wire logic [31:0] w1 = sync2_r[sfr_pkg::COND_W+32 +: 32];

  // soft faults are the three trips
  wire logic any_soft_fault = cond[sfr_pkg::C_CURR_TRIP] | cond[sfr_pkg::C_VOLT_TRIP]
                            | cond[sfr_pkg::C_PWR_TRIP];
  // hard faults are the four protections
  wire logic any_hard_fault = cond[sfr_pkg::C_VOLT_PROT] | cond[sfr_pkg::C_CURR_PROT]
                            | cond[sfr_pkg::C_TEMP_PROT] | cond[sfr_pkg::C_SENSE_LOST];

  // questionable word; bits 16..31 are unused and stay zero
  logic [31:0] ques_nxt;
  always_comb begin
    ques_nxt = 32'h0000_0000;
    ques_nxt[sfr_pkg::Q_REG_POWER:sfr_pkg::Q_VOLT_PROT] =
      cond[sfr_pkg::C_REG_POWER:sfr_pkg::C_VOLT_PROT];
    ques_nxt[sfr_pkg::Q_ANY_SOFT] = any_soft_fault;
    ques_nxt[sfr_pkg::Q_ANY_HARD] = any_hard_fault;
    ques_nxt[sfr_pkg::Q_INTERLOCK] = cond[sfr_pkg::C_INTERLOCK];
    ques_nxt[sfr_pkg::Q_SUPPLY_LOST] = cond[sfr_pkg::C_SUPPLY_LOST];
    ques_nxt[sfr_pkg::Q_IO_FAULT] = cond[sfr_pkg::C_IO_FAULT];
  end

  // word 0: device-owned bits override the raw pin vector
  logic [31:0] word0_nxt;
  always_comb begin
    word0_nxt = op & sfr_pkg::W0_USED_MASK;
    word0_nxt[sfr_pkg::W0_STANDBY] = ~output_on_i;
    word0_nxt[sfr_pkg::W0_LIVE] = output_on_i;
    word0_nxt[sfr_pkg::W0_CURR_TRIP] = cond[sfr_pkg::C_CURR_TRIP];
    word0_nxt[sfr_pkg::W0_VOLT_TRIP] = cond[sfr_pkg::C_VOLT_TRIP];
    word0_nxt[sfr_pkg::W0_PWR_TRIP] = cond[sfr_pkg::C_PWR_TRIP];
    word0_nxt[sfr_pkg::W0_INTERLOCK] = cond[sfr_pkg::C_INTERLOCK];
  end

  // live registers, refreshed every cycle, never cleared by a read
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ques_r <= 32'h0000_0000;
      word0_r <= 32'h0000_0000;
      word1_r <= 32'h0000_0000;
    end else begin
      ques_r <= ques_nxt;
      word0_r <= word0_nxt;
      word1_r <= w1;
    end
  end

  assign ques_o = ques_r;
  assign word0_o = word0_r;
  assign word1_o = word1_r;

endmodule

/* verif/sfr_map_assertions.sv */
`timescale 1ns/1ps
// watches the service port and control outputs of the register map
module sfr_map_assertions (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire logic req_set_i,
  input wire logic [15:0] req_instance_i,
  input wire logic [31:0] req_data_i,
  input wire logic resp_valid_o,
  input wire logic resp_error_o,
  input wire logic [31:0] resp_data_o,
  input wire logic output_enable_o,
  input wire logic config_locked_o,
  input wire logic restore_defaults_o,
  input wire logic target_update_o,
  input wire logic [3:0] target_index_o,
  input wire logic [31:0] target_data_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // request strobes split by service kind
  wire logic set_req = req_valid_i && req_set_i;
  wire logic get_req = req_valid_i && !req_set_i;
  sequence s_ok;
    resp_valid_o && !resp_error_o;
  endsequence
  // a refusal carries no data, so nothing stale leaks out
  sequence s_err;
    resp_valid_o && resp_error_o && resp_data_o == 32'h0000_0000;
  endsequence
  a_answer_latency: assert property (req_valid_i |-> ##2 resp_valid_o)
    else $error("answer not two cycles after request");
  a_no_stray_answer: assert property (resp_valid_o |-> $past(req_valid_i, 2))
    else $error("answer without request");
  a_ques_no_write: assert property (set_req && req_instance_i == 16'h000B |-> ##2 s_err)
    else $error("questionable register accepted a write");
  a_ques_upper_zero: assert property (get_req && req_instance_i == 16'h000B
    |-> ##2 s_ok ##0 resp_data_o[31:16] == 16'h0000) else $error("questionable upper bits set");
  a_status_no_write: assert property (set_req && req_instance_i == 16'h000D |-> ##2 s_err)
    else $error("status register accepted a write");
  a_meas_no_write: assert property (set_req
    && req_instance_i inside {16'h0101, 16'h0102, 16'h0103} |-> ##2 s_err)
    else $error("measurement accepted a write");
  a_target_update: assert property (set_req && req_instance_i == 16'h0201
    && !config_locked_o |=> target_update_o && target_index_o == 4'h0
    && target_data_o == $past(req_data_i)) else $error("current target not forwarded");
  a_target_get_refused: assert property (get_req && req_instance_i == 16'h0201
    |-> ##2 s_err) else $error("write instance answered a read");
  a_locked_refuse: assert property (set_req && config_locked_o && req_instance_i == 16'h0201
    |=> !target_update_o ##1 s_err) else $error("locked target write accepted");
  a_restore_pulse: assert property (set_req && req_instance_i == 16'h0701
    && !config_locked_o |=> restore_defaults_o) else $error("restore not pulsed");
  a_output_off: assert property (set_req && req_instance_i == 16'h000F
    && !req_data_i[0] |=> !output_enable_o) else $error("output stayed on");
endmodule

bind sfr_register_map sfr_map_assertions sfr_map_assertions_i (.core_clk_i, .reset_i,
  .req_valid_i, .req_set_i, .req_instance_i, .req_data_i, .resp_valid_o, .resp_error_o,
  .resp_data_o, .output_enable_o, .config_locked_o, .restore_defaults_o, .target_update_o,
  .target_index_o, .target_data_o);

/* verif/sfr_originator.sv */
`timescale 1ns/1ps
// fieldbus originator: one Get or Set service at a time, waits for the answer
module sfr_originator (
  input wire logic core_clk_i,
  output logic req_valid_o,
  output logic req_set_o,
  output logic [15:0] req_instance_o,
  output logic [31:0] req_data_o,
  input wire logic resp_valid_i,
  input wire logic resp_error_i,
  input wire logic [31:0] resp_data_i,
  input wire logic [31:0] resp_data_hi_i
);
  initial begin
    req_valid_o = 1'b0;
    req_set_o = 1'b0;
    req_instance_o = 16'h0000;
    req_data_o = 32'h0000_0000;
  end
  // a missing answer leaves unknowns, so the caller's compare fails
  task automatic service(input logic set, input logic [15:0] inst, input logic [31:0] data,
                         output logic err, output logic [31:0] rd, output logic [31:0] hi);
    err = 1'bx;
    rd = 'x;
    hi = 'x;
    @(posedge core_clk_i);
    req_valid_o <= 1'b1;
    req_set_o <= set;
    req_instance_o <= inst;
    req_data_o <= data;
    @(posedge core_clk_i);
    req_valid_o <= 1'b0;
    // answer stands one cycle: look mid-cycle, bounded wait
    for (int i = 0; i < 6; i++) begin
      @(negedge core_clk_i);
      if (resp_valid_i === 1'b1) begin
        err = resp_error_i;
        rd = resp_data_i;
        hi = resp_data_hi_i;
        break;
      end
    end
  endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [13:0] pins = '0; // live condition pins, questionable order
  logic [31:0] ops = '0, ops1 = '0, mc = '0, mv = '0, mp = '0;
  wire logic rqv, rqs, rv, re, oe;
  wire logic [15:0] inst;
  wire logic [31:0] wd, rd, rdh;
  integer seed = 32'hb156;
  int n_fail = 0;
  int comparisons = 0;
  logic e, oe_m = 1'b0; // oe_m: expected output state
  logic [31:0] d, h, shadow [16];
  // refused services: {set, instance}
  logic [16:0] bad [12] = '{{1'b1, 16'h000B}, {1'b1, 16'h000D}, {1'b1, 16'h0010},
    {1'b1, 16'h0102}, {1'b1, 16'h0202}, {1'b0, 16'h0201}, {1'b0, 16'h000F}, {1'b0, 16'h0703},
    {1'b0, 16'h0701}, {1'b1, 16'h000C}, {1'b0, 16'h0708}, {1'b1, 16'h0702}};
  always #2 core_clk_i = ~core_clk_i;

  sfr_originator sfr_originator_i (.core_clk_i(core_clk_i), .req_valid_o(rqv), .req_set_o(rqs),
    .req_instance_o(inst), .req_data_o(wd), .resp_valid_i(rv), .resp_error_i(re),
    .resp_data_i(rd), .resp_data_hi_i(rdh));
  sfr_register_map sfr_register_map_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .req_valid_i(rqv), .req_set_i(rqs), .req_instance_i(inst), .req_data_i(wd),
    .resp_valid_o(rv), .resp_error_o(re), .resp_data_o(rd), .resp_data_hi_o(rdh),
    .read_measured_current_i(mc), .read_measured_voltage_i(mv), .read_measured_power_i(mp),
    .volt_protect_fault_i(pins[0]), .curr_trip_fault_i(pins[1]), .volt_trip_fault_i(pins[2]),
    .power_trip_fault_i(pins[3]), .curr_protect_fault_i(pins[4]),
    .temp_protect_fault_i(pins[5]), .sense_lost_fault_i(pins[6]),
    .regulating_current_i(pins[7]), .regulating_voltage_i(pins[8]),
    .regulating_resistance_i(pins[9]), .regulating_power_i(pins[10]),
    .interlock_open_flag_i(pins[11]), .input_supply_lost_i(pins[12]),
    .io_input_fault_i(pins[13]), .op_status_i(ops), .op_status_word1_i(ops1),
    .output_enable_o(oe), .config_locked_o(), .restore_defaults_o(), .target_update_o(),
    .target_index_o(), .target_data_o());

  // expected questionable word: soft OR over trips, hard OR over protections
  function automatic logic [31:0] exp_ques(logic [13:0] p);
    return {16'h0000, p[13:11], p[0] | p[4] | p[5] | p[6], |p[3:1], p[10:0]};
  endfunction
  // expected status word 0: device-owned bits over the raw word, unused bits zero
  function automatic logic [31:0] exp_w0(logic [13:0] p, logic [31:0] o, logic on);
    return (o & 32'h7FCF_FF80) | {11'h000, p[11], 13'h0000, p[3:1], 2'b00, on, !on};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one service plus comparison of refusal flag and data
  task automatic op(logic s, logic [15:0] i, logic [31:0] w, logic xe, logic [31:0] xd);
    sfr_originator_i.service(s, i, w, e, d, h);
    chk("error flag", {31'h0, e}, {31'h0, xe});
    chk("answer data", d, xd);
  endtask
  // new pins and measurements; wait past the synchronisers
  task automatic drive_pins(logic [13:0] p);
    @(posedge core_clk_i);
    pins <= p;
    ops <= $random(seed);
    ops1 <= $random(seed);
    mc <= $random(seed);
    mv <= $random(seed);
    mp <= $random(seed);
    repeat (5) @(posedge core_clk_i);
    if (p[0] | p[4] | p[5] | p[6]) oe_m = 1'b0;
  endtask
  task automatic close_out;
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    op(1'b0, 16'h0202, 0, 1'b0, 32'h0000_0000);
    op(1'b0, 16'h0010, 0, 1'b0, 32'h0000_0000);
    // every setting written, then read back one instance higher
    foreach (shadow[k]) begin
      shadow[k] = $random(seed);
      op(1'b1, sfr_pkg::SET_WR_INST[k], shadow[k], 1'b0, 0);
    end
    foreach (shadow[k]) op(1'b0, sfr_pkg::SET_WR_INST[k] + 16'h0001, 0, 1'b0, shadow[k]);
    foreach (bad[k]) op(bad[k][16], bad[k][15:0], $random(seed), 1'b1, 0);
    // random live conditions (all set on the first pass); measurements read once, questionable and status words twice
    for (int n = 0; n < 20; n++) begin
      drive_pins(n == 0 ? 14'h3FFF : 14'($random(seed)));
      op(1'b0, 16'h0101, 0, 1'b0, mc);
      op(1'b0, 16'h0102, 0, 1'b0, mv);
      op(1'b0, 16'h0103, 0, 1'b0, mp);
      op(1'b0, 16'h000B, 0, 1'b0, exp_ques(pins));
      op(1'b0, 16'h000B, 0, 1'b0, exp_ques(pins));
      op(1'b0, 16'h000D, 0, 1'b0, exp_w0(pins, ops, oe_m));
      chk("status word 1", h, ops1);
      op(1'b0, 16'h000D, 0, 1'b0, exp_w0(pins, ops, oe_m));
      chk("status word 1", h, ops1);
    end
    // output on, then a hard fault forces it off
    drive_pins(14'h0000);
    op(1'b1, 16'h000F, 1, 1'b0, 0);
    oe_m = 1'b1;
    op(1'b0, 16'h0010, 0, 1'b0, 1);
    op(1'b0, 16'h000D, 0, 1'b0, exp_w0(pins, ops, oe_m));
    drive_pins(14'h0001);
    chk("output enable", {31'h0, oe}, {31'h0, oe_m});
    op(1'b0, 16'h000D, 0, 1'b0, exp_w0(pins, ops, oe_m));
    // lock blocks targets and restore; unlock lets restore clear them
    drive_pins(14'h0000);
    op(1'b1, 16'h0703, 1, 1'b0, 0);
    op(1'b0, 16'h0702, 0, 1'b0, 1);
    op(1'b1, 16'h0201, 32'h0000_0005, 1'b1, 0);
    op(1'b1, 16'h0701, 0, 1'b1, 0);
    op(1'b0, 16'h0202, 0, 1'b0, shadow[0]);
    op(1'b1, 16'h000F, 0, 1'b0, 0);
    op(1'b1, 16'h0703, 0, 1'b0, 0);
    op(1'b1, 16'h0701, 0, 1'b0, 0);
    op(1'b0, 16'h0202, 0, 1'b0, 32'h0000_0000);
    close_out();
  end
  // about 200 services of under 10 cycles each fit well inside this
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule
